// ---- include/pnvl_pkg.sv ----
// Purpose: Shared constants and types for the persistent flag latch bank
// Assumes: One clock domain; external non-volatile store holds the image
// Notes: Image bit n is latch n; a set bit means the latch is true
package pnvl_pkg;

	// Number of latches in the bank
	localparam int NUM_LATCHES = 16;

	// Value the latch flops take under reset, before the image is restored
	localparam logic [NUM_LATCHES-1:0] LATCH_RST = 16'h0000;

	// Type setting encoding for one latch
	localparam logic TYPE_CLR_DOM = 1'b0;
	localparam logic TYPE_SET_DOM = 1'b1;

	// Write-back request to the non-volatile store
	typedef struct packed {
		logic req;
		logic [NUM_LATCHES-1:0] data;
	} pnvl_nv_wr_t;

	// Write-back value under reset
	localparam pnvl_nv_wr_t NV_WR_RST = '{req: 1'b0, data: LATCH_RST};

endpackage

// ---- verilog/pnvl_cell.sv ----
// Purpose: One persistent flag latch with selectable dominance
// Assumes: Set and clear inputs are synchronous to mclk
// Notes: Evaluation only happens while run_en is high
`timescale 1ns/1ps
`default_nettype none
module pnvl_cell (
	input wire logic mclk,
	input wire logic rst,
	input wire logic run_en,
	input wire logic load_en,
	input wire logic load_val,
	input wire logic set_in,
	input wire logic clr_in,
	input wire logic set_dom,
	output logic q,
	output logic q_nxt
);

	// Next state from the operation table
	always_comb begin
		case ({set_in, clr_in})
			2'b10: q_nxt = 1'b1;
			2'b01: q_nxt = 1'b0;
			2'b11: q_nxt = (set_dom == pnvl_pkg::TYPE_SET_DOM);
			default: q_nxt = q;
		endcase
	end

	// Restore has priority so a stale input cannot override the saved image
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= pnvl_pkg::LATCH_RST[0];
		end else if (load_en) begin
			q <= load_val;
		end else if (run_en) begin
			q <= q_nxt;
		end
	end

endmodule
`default_nettype wire

// ---- verilog/pnvl_bank.sv ----
// Purpose: Bank of persistent flag latches with true and false outputs
// Assumes: An external non-volatile store answers one read after reset
// Notes: Latches stay frozen until the saved image has been restored
//
// Behaviour
// - Sixteen latches, false output inverts true output
// - State survives power loss via non-volatile image
// - Both asserted: type setting picks the winner
// - Set alone makes the latch true
// - Clear alone makes the latch false
`timescale 1ns/1ps
`default_nettype none
module pnvl_bank #(
	parameter int N = pnvl_pkg::NUM_LATCHES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [N-1:0] set_in,
	input wire logic [N-1:0] clr_in,
	input wire logic [N-1:0] set_dom,
	output logic nv_rd_req,
	input wire logic nv_rd_valid,
	input wire logic [N-1:0] nv_rd_data,
	output pnvl_pkg::pnvl_nv_wr_t nv_wr,
	output logic restored,
	output logic [N-1:0] latch_true,
	output logic [N-1:0] latch_false
);

	typedef enum logic [1:0] {
		ST_BOOT,
		ST_WAIT,
		ST_RUN
	} pnvl_state_t;

	pnvl_state_t st_r;
	pnvl_state_t st_nxt;
	logic run_en;
	logic load_en;
	logic [N-1:0] q;
	logic [N-1:0] q_nxt;

	// Boot sequence: ask for the image, wait for it, then run
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_BOOT: st_nxt = ST_WAIT;
			ST_WAIT: begin
				if (nv_rd_valid) begin
					st_nxt = ST_RUN;
				end
			end
			ST_RUN: st_nxt = ST_RUN;
			default: st_nxt = ST_BOOT;
		endcase
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_r <= ST_BOOT;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Read request is high for the whole boot state: all of reset, then one cycle
	assign nv_rd_req = (st_r == ST_BOOT);
	// Load the saved image, never clear it, on the way out of reboot
	assign load_en = (st_r == ST_WAIT) && nv_rd_valid;
	assign run_en = (st_r == ST_RUN);
	assign restored = run_en;

	// One latch cell per flag
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_cell
			pnvl_cell u_cell (
				.mclk(mclk),
				.rst(rst),
				.run_en(run_en),
				.load_en(load_en),
				.load_val(nv_rd_data[i]),
				.set_in(set_in[i]),
				.clr_in(clr_in[i]),
				.set_dom(set_dom[i]),
				.q(q[i]),
				.q_nxt(q_nxt[i])
			);
		end
	endgenerate

	// Complementary outputs come from the same flops, so they never skew
	assign latch_true = q;
	assign latch_false = ~q;

	// Write back every change made in the run state so a power loss loses nothing.
	// Writing only on change keeps wear on the store low.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			nv_wr <= pnvl_pkg::NV_WR_RST;
		end else begin
			nv_wr.req <= run_en && (q_nxt != q);
			nv_wr.data <= q_nxt;
		end
	end

	// Checks below watch what this block drives against its inputs

	// Image delivery during the wait state
	sequence image_arrives;
		(st_r == ST_WAIT) && nv_rd_valid;
	endsequence

	// Run state is reached with the offered image in the latches
	sequence image_loaded;
		restored && (latch_true == $past(nv_rd_data));
	endsequence

	property restore_p;
		@(posedge mclk) disable iff (rst)
		image_arrives |=> image_loaded;
	endproperty

	restore_image_a: assert property (restore_p)
		else $error("latches not restored from saved image");

	// Both outputs share one flop; this guards against a later split
	property inverse_p;
		@(posedge mclk) disable iff (rst)
		(latch_false ^ latch_true) == {N{1'b1}};
	endproperty

	output_inverse_a: assert property (inverse_p)
		else $error("false output not inverse of true output");

	// The restore edge is not written back: the store already has it
	property write_back_p;
		@(posedge mclk) disable iff (rst)
		restored && $past(restored) && $changed(latch_true)
		|-> nv_wr.req && (nv_wr.data == latch_true);
	endproperty

	write_back_a: assert property (write_back_p)
		else $error("latch change not written back");

	// No write without a change, so the store is not worn for nothing
	property idle_write_p;
		@(posedge mclk) disable iff (rst)
		restored && $past(restored) && $stable(latch_true)
		|-> !nv_wr.req;
	endproperty

	no_idle_write_a: assert property (idle_write_p)
		else $error("write-back issued with no latch change");

	// Written image always matches the latches it was taken from
	property wr_match_p;
		@(posedge mclk) disable iff (rst)
		nv_wr.req |-> (nv_wr.data == latch_true);
	endproperty

	wr_data_match_a: assert property (wr_match_p)
		else $error("written image differs from latches");

	// Operands must not reach the latches before the image is back
	property frozen_p;
		@(posedge mclk) disable iff (rst)
		!restored && !load_en |=> $stable(latch_true);
	endproperty

	frozen_boot_a: assert property (frozen_p)
		else $error("latch moved before restore finished");

	// One read per reset: a second read could replay an old image
	property rd_once_p;
		@(posedge mclk) disable iff (rst)
		nv_rd_req |=> !nv_rd_req;
	endproperty

	rd_req_pulse_a: assert property (rd_once_p)
		else $error("image read requested more than once");

	// Only reset may send the bank back to waiting for the image
	property sticky_p;
		@(posedge mclk) disable iff (rst)
		restored |=> restored;
	endproperty

	restored_sticky_a: assert property (sticky_p)
		else $error("run state left without reset");

	generate
		for (i = 0; i < N; i++) begin : g_chk
			property set_only_p;
				@(posedge mclk) disable iff (rst)
				restored && set_in[i] && !clr_in[i]
				|=> latch_true[i];
			endproperty

			set_only_a: assert property (set_only_p)
				else $error("set alone did not make latch true");

			property clr_only_p;
				@(posedge mclk) disable iff (rst)
				restored && !set_in[i] && clr_in[i]
				|=> !latch_true[i];
			endproperty

			clr_only_a: assert property (clr_only_p)
				else $error("clear alone did not make latch false");

			property both_p;
				@(posedge mclk) disable iff (rst)
				restored && set_in[i] && clr_in[i]
				|=> latch_true[i] == $past(set_dom[i]);
			endproperty

			both_dom_a: assert property (both_p)
				else $error("dominance not honoured on both inputs");

			property hold_p;
				@(posedge mclk) disable iff (rst)
				restored && !set_in[i] && !clr_in[i]
				|=> latch_true[i] == $past(latch_true[i]);
			endproperty

			latch_hold_a: assert property (hold_p)
				else $error("latch changed with no input asserted");
		end
	endgenerate

endmodule
`default_nettype wire

// ---- tb/pnvl_bank_tb.sv ----
// Purpose: Self-checking bench for the persistent flag latch bank
// Assumes: Inputs change on the falling edge of mclk
// Notes: The bench plays the non-volatile store itself
`timescale 1ns/1ps
`default_nettype none
module pnvl_bank_tb;
	logic mclk, rst, nv_rd_req, nv_rd_valid, restored;
	logic [15:0] set_in, clr_in, set_dom, nv_rd_data, latch_true;
	logic [15:0] latch_false;
	logic [15:0] store_r = 16'h0000;
	pnvl_pkg::pnvl_nv_wr_t nv_wr;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	pnvl_bank dut (.mclk(mclk), .rst(rst), .set_in(set_in),
		.clr_in(clr_in), .set_dom(set_dom), .nv_rd_req(nv_rd_req),
		.nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data),
		.nv_wr(nv_wr), .restored(restored), .latch_true(latch_true),
		.latch_false(latch_false));
	// Clock, 50 ns period
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// Store keeps the last image written back, as flash would
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (nv_wr.req === 1'b1) store_r <= nv_wr.data;
		if (cyc == 3000) begin
			error_cnt++;
			conclude();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Drive one pair of operands, let one edge act on it
	task automatic step(input logic [15:0] s, c, e);
		@(negedge mclk);
		set_in = s;
		clr_in = c;
		@(negedge mclk);
		chk(latch_false, ~e);
	endtask
	// Power-up: set operands are held high to show they are ignored
	task automatic t_boot(input logic [15:0] img);
		rst = 1'b1;
		set_in = 16'hffff;
		repeat (10) @(negedge mclk);
		chk({15'h0000, nv_rd_req}, 16'h0001);
		chk(latch_false, 16'hffff);
		rst = 1'b0;
		@(negedge mclk);
		chk({15'h0000, nv_rd_req}, 16'h0000);
		chk({15'h0000, restored}, 16'h0000);
		chk(latch_true, 16'h0000);
		nv_rd_valid = 1'b1;
		nv_rd_data = img;
		@(negedge mclk);
		nv_rd_valid = 1'b0;
		set_in = 16'h0000;
		chk(latch_true, img);
		chk(latch_false, ~img);
		chk({15'h0000, restored}, 16'h0001);
		$display("test boot done");
	endtask
	task automatic t_ops();
		set_dom = 16'h00ff;
		step(16'hffff, 16'hffff, 16'h00ff);
		chk(latch_true, 16'h00ff);
		step(16'h0f0f, 16'h0000, 16'h0fff);
		chk(latch_true, 16'h0fff);
		chk({15'h0000, nv_wr.req}, 16'h0001);
		chk(nv_wr.data, 16'h0fff);
		step(16'h0000, 16'h00f0, 16'h0f0f);
		chk(latch_true, 16'h0f0f);
		step(16'h0000, 16'h0000, 16'h0f0f);
		chk(latch_true, 16'h0f0f);
		chk({15'h0000, nv_wr.req}, 16'h0000);
		$display("test ops done");
	endtask
	// Reboot from what the store kept; the last image must come back
	task automatic t_reboot();
		t_boot(store_r);
		chk(latch_true, 16'h0f0f);
		$display("test reboot done");
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Main sequence: boot, operate, then reboot from the saved image
	initial begin
		rst = 1'b1;
		set_in = 16'h0000;
		clr_in = 16'h0000;
		set_dom = 16'h0000;
		nv_rd_valid = 1'b0;
		nv_rd_data = 16'h0000;
		t_boot(16'ha5c3);
		t_ops();
		t_reboot();
		conclude();
	end
endmodule
`default_nettype wire
